// file: verilog/clk_sel_pkg.sv
package clk_sel_pkg;

    // register word offsets on the byte-addressed bus
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFS_CLOCK_DIVISOR = 4'h0;
    localparam logic [3:0] OFS_PLL_FEEDBACK = 4'h4;
    localparam logic [3:0] OFS_SOURCE_CTRL = 4'h8;
    localparam logic [3:0] OFS_PLL_STATUS = 4'hC;

    localparam logic [15:0] CLOCK_DIVISOR_RST = 16'h3040;
    localparam logic [8:0] PLL_FEEDBACK_RST = 9'h01E;

    // bit positions inside the source control register
    localparam int SRC_REQ_LSB = 0;
    localparam int SRC_GO_BIT = 3;

    // timing figures
    localparam int MCLK_HZ = 25_000_000;
    localparam int MAX_INSTR_HZ = 40_000_000;
    localparam int SLOW_RC_HZ = 32_768;

    // oscillator pins, synchronised as one vector
    localparam int NUM_PINS = 5;
    localparam int PIN_FRC = 0;
    localparam int PIN_PRI = 1;
    localparam int PIN_LP = 2;
    localparam int PIN_SLOW = 3;
    localparam int PIN_VCO = 4;

    localparam logic [9:0] FRC_DIV16_EVENTS = 10'h010;
    localparam logic [7:0] PRESCALE_OFFSET = 8'h02;

    typedef enum logic [2:0] {
        SRC_FAST_RC = 3'h0,
        SRC_FAST_RC_PLL = 3'h1,
        SRC_PRIMARY = 3'h2,
        SRC_PRIMARY_PLL = 3'h3,
        SRC_LP_XTAL = 3'h4,
        SRC_SLOW_RC = 3'h5,
        SRC_FAST_RC_DIV16 = 3'h6,
        SRC_FAST_RC_DIVN = 3'h7
    } src_sel_t;

    typedef enum logic [1:0] {
        PM_EXTERNAL_CLOCK_INPUT = 2'h0,
        PM_STANDARD_CRYSTAL = 2'h1,
        PM_HIGH_SPEED_CRYSTAL = 2'h2,
        PM_RESERVED = 2'h3
    } prim_mode_t;

    typedef enum logic [3:0] {
        CM_FAST_RC = 4'h0,
        CM_FAST_RC_PLL = 4'h1,
        CM_PRI_EXT = 4'h2,
        CM_PRI_STD = 4'h3,
        CM_PRI_HS = 4'h4,
        CM_PRI_PLL_EXT = 4'h5,
        CM_PRI_PLL_STD = 4'h6,
        CM_PRI_PLL_HS = 4'h7,
        CM_LP_XTAL = 4'h8,
        CM_SLOW_RC = 4'h9,
        CM_FAST_RC_DIV16 = 4'hA,
        CM_FAST_RC_DIVN = 4'hB
    } clk_mode_t;

    localparam logic [3:0] NUM_CLOCK_MODES = 4'hC;

    typedef enum logic [1:0] {
        SW_IDLE = 2'h0,
        SW_WAIT = 2'h1,
        SW_DONE = 2'h3
    } sw_state_t;

    typedef struct packed {
        logic rsvd_hi;
        logic [2:0] doze_ratio;
        logic doze_enable;
        logic [2:0] fast_rc_postscale;
        logic [1:0] pll_output_postscale;
        logic rsvd_lo;
        logic [4:0] pll_input_prescale;
    } clock_divisor_t;

    typedef struct packed {
        logic [5:0] prescale_factor;
        logic [9:0] feedback_multiplier;
        logic [3:0] postscale_factor;
    } pll_cfg_t;

    function automatic logic [3:0] post_factor(input logic [1:0] f);
        case (f)
            2'h0: post_factor = 4'h2;
            2'h3: post_factor = 4'h8;
            default: post_factor = 4'h4;
        endcase
    endfunction : post_factor

    // source edges counted per half period of the oscillator output
    function automatic logic [9:0] events_per_phase(input src_sel_t s, input logic [2:0] frc_ps,
                                                    input logic [1:0] post);
        case (s)
            SRC_FAST_RC_DIVN: events_per_phase = 10'h002 << frc_ps;
            SRC_FAST_RC_DIV16: events_per_phase = FRC_DIV16_EVENTS;
            SRC_FAST_RC_PLL, SRC_PRIMARY_PLL: events_per_phase = {6'h00, post_factor(post)};
            default: events_per_phase = 10'h001;
        endcase
    endfunction : events_per_phase

    function automatic clk_mode_t clock_mode(input src_sel_t s, input prim_mode_t p);
        logic [3:0] pri;
        pri = (p == PM_HIGH_SPEED_CRYSTAL) ? 4'h2 : (p == PM_STANDARD_CRYSTAL) ? 4'h1 : 4'h0;
        case (s)
            SRC_FAST_RC: clock_mode = CM_FAST_RC;
            SRC_FAST_RC_PLL: clock_mode = CM_FAST_RC_PLL;
            SRC_PRIMARY: clock_mode = clk_mode_t'(4'(CM_PRI_EXT) + pri);
            SRC_PRIMARY_PLL: clock_mode = clk_mode_t'(4'(CM_PRI_PLL_EXT) + pri);
            SRC_LP_XTAL: clock_mode = CM_LP_XTAL;
            SRC_SLOW_RC: clock_mode = CM_SLOW_RC;
            SRC_FAST_RC_DIV16: clock_mode = CM_FAST_RC_DIV16;
            default: clock_mode = CM_FAST_RC_DIVN;
        endcase
    endfunction : clock_mode

endpackage : clk_sel_pkg

// file: verilog/pin_event_sync.sv
`timescale 1ns/1ps
module pin_event_sync (
    input wire logic i_mclk, // system clock
    input wire logic i_rst_n, // async reset, active low
    input wire logic i_ce, // clock enable
    input wire logic [clk_sel_pkg::NUM_PINS-1:0] i_pins, // asynchronous oscillator pins
    output logic [clk_sel_pkg::NUM_PINS-1:0] o_level, // synchronised level
    output logic [clk_sel_pkg::NUM_PINS-1:0] o_event // pulse on either edge
);
    import clk_sel_pkg::*;

    logic [NUM_PINS-1:0] meta_ff;
    logic [NUM_PINS-1:0] sync_ff;
    logic [NUM_PINS-1:0] last_ff;

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
            last_ff <= '0;
        end
        else if (i_ce)
        begin
            meta_ff <= i_pins;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    // only the second and third stages feed the edge detector
    assign o_level = sync_ff;
    assign o_event = sync_ff ^ last_ff;

endmodule : pin_event_sync

// file: verilog/clock_select_pll.sv
// Contract
// - fast RC divided 1:2 to 1:256
// - power-on source from two config fields
// - unprogrammed configuration selects fast RC
// - twelve distinct clock modes offered
// - instruction and peripheral clock: oscillator over two
// - peripheral equals cpu clock unless doze
// - PLL prescale 2 to 33, field plus two
// - feedback multiplier equals field plus two
// - PLL postscale 2, 4 or 8
// - PLL output: input times M over N1*N2
// - slow RC feeds watchdog and fail monitor
// - instruction clock up to 40 MHz
// - source select decode, eight sources
// - primary mode decode: HS, XT, EC
//
// The Avalon-MM register port and the register addresses were decided locally.
`timescale 1ns/1ps
module clock_select_pll (
    input wire logic i_mclk, // 25 MHz system clock
    input wire logic i_rst_n, // async reset, active low
    input wire logic i_ce, // clock enable, low freezes all state
    input wire logic [clk_sel_pkg::ADDR_W-1:0] i_address, // avalon byte address
    input wire logic i_read, // avalon read
    input wire logic i_write, // avalon write
    input wire logic [31:0] i_writedata, // avalon write data
    input wire logic [3:0] i_byteenable, // avalon byte enables
    output logic [31:0] o_readdata, // avalon read data
    output logic o_waitrequest, // avalon wait request
    input wire logic i_frc_clk, // fast internal rc pin
    input wire logic i_primary_clk, // primary oscillator pin
    input wire logic i_lp_xtal_clk, // low-power crystal pin
    input wire logic i_slow_rc_clk, // slow internal rc pin
    input wire logic i_vco_clk, // analog VCO output
    input wire logic [2:0] i_initial_source_select, // nonvolatile source field
    input wire logic [1:0] i_primary_mode_select, // nonvolatile primary mode field
    input wire logic i_config_erased, // configuration unprogrammed
    output logic o_osc_clk, // oscillator output
    output logic o_instr_clk, // instruction clock
    output logic o_periph_clk, // peripheral clock
    output logic o_cpu_clk, // cpu clock after doze
    output logic o_pll_ref, // prescaled reference to phase detector
    output logic o_pll_fb, // feedback-divided VCO to phase detector
    output logic o_pll_enable, // PLL mode active
    output clk_sel_pkg::pll_cfg_t o_pll_cfg, // PLL factors
    output clk_sel_pkg::clk_mode_t o_clock_mode, // active clock mode
    output clk_sel_pkg::prim_mode_t o_primary_mode, // primary oscillator mode
    output logic o_wdt_ref, // watchdog reference clock
    output logic o_fail_mon_ref // clock fail monitor reference
);
    import clk_sel_pkg::*;

    logic [NUM_PINS-1:0] pin_level;
    logic [NUM_PINS-1:0] pin_event;

    pin_event_sync u_sync (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_pins({i_vco_clk, i_slow_rc_clk, i_lp_xtal_clk, i_primary_clk, i_frc_clk}),
        .o_level(pin_level),
        .o_event(pin_event)
    );

    clock_divisor_t clock_divisor_reg_ff;
    logic [8:0] fbd_ff;
    src_sel_t req_src_ff;
    logic sw_pend_ff;
    sw_state_t sw_state_ff;
    src_sel_t active_src_ff;
    prim_mode_t pmode_ff;
    logic cfg_done_ff;
    logic [9:0] div_n_ff;
    logic [9:0] osc_cnt_ff;
    logic osc_ff;
    logic instr_ff;
    logic cpu_ff;
    logic [6:0] doze_cnt_ff;
    logic [5:0] ref_cnt_ff;
    logic [9:0] fb_cnt_ff;
    logic wait_ff;

    function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [15:0] wd,
                                               input logic [1:0] be);
        lane_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction : lane_merge

    // bus: one wait cycle, answer at the second edge
    wire bus_req = i_read || i_write;
    wire bus_wr = i_write && !wait_ff;
    wire nxt_wait = !(bus_req && wait_ff);
    wire wr_div = bus_wr && (i_address == OFS_CLOCK_DIVISOR);
    wire wr_fbd = bus_wr && (i_address == OFS_PLL_FEEDBACK);
    wire wr_src = bus_wr && (i_address == OFS_SOURCE_CTRL) && i_byteenable[0];
    wire [15:0] nxt_div_word = lane_merge(clock_divisor_reg_ff, i_writedata[15:0], i_byteenable[1:0]);
    wire [15:0] nxt_fbd_word = lane_merge({7'h00, fbd_ff}, i_writedata[15:0], i_byteenable[1:0]);
    wire [31:0] src_word = {18'h0_0000, o_clock_mode, o_pll_enable, pmode_ff, active_src_ff,
                            sw_pend_ff, req_src_ff};
    wire [31:0] rd_mux = (i_address == OFS_CLOCK_DIVISOR) ? {16'h0000, clock_divisor_reg_ff} :
                         (i_address == OFS_PLL_FEEDBACK) ? {23'h00_0000, fbd_ff} :
                         (i_address == OFS_SOURCE_CTRL) ? src_word :
                         (i_address == OFS_PLL_STATUS) ? {12'h000, o_pll_cfg} : 32'h0000_0000;

    // switch request: a set in the same cycle as the clear wins
    wire sw_set = wr_src && i_writedata[SRC_GO_BIT];
    wire nxt_pend = sw_set || (sw_pend_ff && (sw_state_ff != SW_DONE));

    // oscillator output from the selected source edges
    wire pll_mode = (active_src_ff == SRC_FAST_RC_PLL) || (active_src_ff == SRC_PRIMARY_PLL);
    wire src_ev = pll_mode ? pin_event[PIN_VCO] :
                  (active_src_ff == SRC_PRIMARY) ? pin_event[PIN_PRI] :
                  (active_src_ff == SRC_LP_XTAL) ? pin_event[PIN_LP] :
                  (active_src_ff == SRC_SLOW_RC) ? pin_event[PIN_SLOW] : pin_event[PIN_FRC];
    wire osc_edge = src_ev && (osc_cnt_ff + 10'h001 >= div_n_ff);
    wire osc_fall = osc_edge && osc_ff;
    wire osc_rise = osc_edge && !osc_ff;
    wire [9:0] nxt_osc_cnt = osc_edge ? 10'h000 : src_ev ? osc_cnt_ff + 10'h001 : osc_cnt_ff;

    // new source and dividers only take over at the end of a high phase
    wire src_apply = osc_fall && (sw_state_ff == SW_WAIT);
    wire src_sel_t nxt_active = src_apply ? req_src_ff : active_src_ff;
    wire [9:0] nxt_div_n = osc_fall ? events_per_phase(nxt_active, clock_divisor_reg_ff.fast_rc_postscale,
                           clock_divisor_reg_ff.pll_output_postscale) : div_n_ff;
    wire src_sel_t cfg_src = i_config_erased ? SRC_FAST_RC :
                             src_sel_t'(i_initial_source_select);

    // instruction clock is the oscillator halved; doze slows only the cpu copy
    wire nxt_instr = instr_ff ^ osc_rise;
    wire doze_on = clock_divisor_reg_ff.doze_enable && (clock_divisor_reg_ff.doze_ratio != 3'h0);
    wire [7:0] doze_span = 8'h01 << clock_divisor_reg_ff.doze_ratio;
    wire [6:0] doze_lim = 7'(doze_span - 8'h01);
    wire doze_last = (doze_cnt_ff == doze_lim);
    wire nxt_cpu = !doze_on ? nxt_instr : (osc_rise && doze_last) ? !cpu_ff : cpu_ff;
    wire [6:0] nxt_doze_cnt = !doze_on ? 7'h00 :
                              !osc_rise ? doze_cnt_ff : doze_last ? 7'h00 : doze_cnt_ff + 7'h01;

    // PLL: the VCO locks when ref and feedback edges match, giving
    wire pll_cfg_t nxt_pll_cfg = '{
        prescale_factor: 6'({3'h0, clock_divisor_reg_ff.pll_input_prescale} + PRESCALE_OFFSET),
        feedback_multiplier: 10'({1'b0, fbd_ff}) + 10'(PRESCALE_OFFSET),
        postscale_factor: post_factor(clock_divisor_reg_ff.pll_output_postscale)
    };
    wire pll_in_ev = (active_src_ff == SRC_PRIMARY_PLL) ? pin_event[PIN_PRI] : pin_event[PIN_FRC];
    wire ref_edge = pll_in_ev && (ref_cnt_ff + 6'h01 >= o_pll_cfg.prescale_factor);
    wire fb_edge = pin_event[PIN_VCO] &&
                   (fb_cnt_ff + 10'h001 >= o_pll_cfg.feedback_multiplier);
    wire [5:0] nxt_ref_cnt = ref_edge ? 6'h00 : pll_in_ev ? ref_cnt_ff + 6'h01 : ref_cnt_ff;
    wire [9:0] nxt_fb_cnt = fb_edge ? 10'h000 :
                            pin_event[PIN_VCO] ? fb_cnt_ff + 10'h001 : fb_cnt_ff;

    sw_state_t nxt_sw_state;
    always_comb
    begin
        case (sw_state_ff)
            SW_IDLE: nxt_sw_state = sw_pend_ff ? SW_WAIT : SW_IDLE;
            SW_WAIT: nxt_sw_state = osc_fall ? SW_DONE : SW_WAIT;
            SW_DONE: nxt_sw_state = SW_IDLE;
            default: nxt_sw_state = SW_IDLE;
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wait_ff <= 1'b1;
            o_waitrequest <= 1'b1;
            o_readdata <= 32'h0000_0000;
            clock_divisor_reg_ff <= CLOCK_DIVISOR_RST;
            fbd_ff <= PLL_FEEDBACK_RST;
            req_src_ff <= SRC_FAST_RC;
            sw_pend_ff <= 1'b0;
            sw_state_ff <= SW_IDLE;
        end
        else if (i_ce)
        begin
            wait_ff <= nxt_wait;
            o_waitrequest <= nxt_wait;
            if (bus_req && wait_ff)
                o_readdata <= rd_mux;
            if (wr_div)
                clock_divisor_reg_ff <= {1'b0, nxt_div_word[14:6], 1'b0, nxt_div_word[4:0]};
            if (wr_fbd)
                fbd_ff <= nxt_fbd_word[8:0];
            if (wr_src)
                req_src_ff <= src_sel_t'(i_writedata[SRC_REQ_LSB+:3]);
            sw_pend_ff <= nxt_pend;
            sw_state_ff <= nxt_sw_state;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cfg_done_ff <= 1'b0;
            active_src_ff <= SRC_FAST_RC;
            pmode_ff <= PM_EXTERNAL_CLOCK_INPUT;
            div_n_ff <= 10'h001;
        end
        else if (i_ce && !cfg_done_ff)
        begin
            cfg_done_ff <= 1'b1;
            active_src_ff <= cfg_src;
            pmode_ff <= prim_mode_t'(i_primary_mode_select);
            div_n_ff <= events_per_phase(cfg_src, clock_divisor_reg_ff.fast_rc_postscale,
                                         clock_divisor_reg_ff.pll_output_postscale);
        end
        else if (i_ce)
        begin
            active_src_ff <= nxt_active;
            div_n_ff <= nxt_div_n;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            osc_cnt_ff <= 10'h000;
            osc_ff <= 1'b0;
            instr_ff <= 1'b0;
            cpu_ff <= 1'b0;
            doze_cnt_ff <= 7'h00;
            ref_cnt_ff <= 6'h00;
            fb_cnt_ff <= 10'h000;
        end
        else if (i_ce)
        begin
            osc_cnt_ff <= nxt_osc_cnt;
            osc_ff <= osc_ff ^ osc_edge;
            instr_ff <= nxt_instr;
            cpu_ff <= nxt_cpu;
            doze_cnt_ff <= nxt_doze_cnt;
            ref_cnt_ff <= nxt_ref_cnt;
            fb_cnt_ff <= nxt_fb_cnt;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_osc_clk <= 1'b0;
            o_instr_clk <= 1'b0;
            o_periph_clk <= 1'b0;
            o_cpu_clk <= 1'b0;
            o_pll_ref <= 1'b0;
            o_pll_fb <= 1'b0;
            o_pll_enable <= 1'b0;
            o_pll_cfg <= '0;
            o_clock_mode <= CM_FAST_RC;
            o_primary_mode <= PM_EXTERNAL_CLOCK_INPUT;
            o_wdt_ref <= 1'b0;
            o_fail_mon_ref <= 1'b0;
        end
        else if (i_ce)
        begin
            o_osc_clk <= osc_ff ^ osc_edge;
            o_instr_clk <= nxt_instr;
            o_periph_clk <= nxt_instr;
            o_cpu_clk <= nxt_cpu;
            o_pll_ref <= o_pll_ref ^ ref_edge;
            o_pll_fb <= o_pll_fb ^ fb_edge;
            o_pll_enable <= pll_mode;
            o_pll_cfg <= nxt_pll_cfg;
            o_clock_mode <= clock_mode(active_src_ff, pmode_ff);
            o_primary_mode <= pmode_ff;
            o_wdt_ref <= pin_level[PIN_SLOW];
            o_fail_mon_ref <= pin_level[PIN_SLOW];
        end
    end

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);

    AST_DIVN_RANGE: assert property (active_src_ff == SRC_FAST_RC_DIVN && cfg_done_ff
        |-> div_n_ff >= 10'h002 && div_n_ff <= 10'h100)
        else $error("divided fast rc factor out of range");
    AST_POR_SOURCE: assert property ($rose(cfg_done_ff) && !$past(i_config_erased)
        |-> active_src_ff == $past(i_initial_source_select))
        else $error("power-on source not taken from configuration");
    AST_UNPROG_FRC: assert property ($rose(cfg_done_ff) && $past(i_config_erased)
        |-> active_src_ff == SRC_FAST_RC)
        else $error("erased configuration did not pick fast rc");
    AST_MODE_COUNT: assert property (o_clock_mode < NUM_CLOCK_MODES)
        else $error("clock mode outside the twelve modes");
    AST_INSTR_HALF: assert property ($changed(o_instr_clk) |-> $rose(o_osc_clk))
        else $error("instruction clock moved without oscillator rise");
    AST_PERIPH_EQ: assert property (!doze_on |=> o_periph_clk == o_cpu_clk)
        else $error("peripheral and cpu clocks differ outside doze");
    AST_PRESCALE: assert property (i_ce && i_rst_n |=> o_pll_cfg.prescale_factor
        == 6'($past(clock_divisor_reg_ff.pll_input_prescale)) + 6'h02)
        else $error("prescale factor is not field plus two");
    AST_MULTIPLIER: assert property (i_ce && i_rst_n |=> o_pll_cfg.feedback_multiplier
        == 10'($past(fbd_ff)) + 10'h002)
        else $error("feedback multiplier is not field plus two");
    AST_POSTSCALE: assert property (o_pll_cfg.postscale_factor inside {4'h0, 4'h2, 4'h4, 4'h8})
        else $error("postscale factor not 2, 4 or 8");
    AST_REF_DIVIDE: assert property ($changed(o_pll_ref) |-> $past(ref_edge))
        else $error("reference toggled without a full prescale count");
    AST_SLOW_REF: assert property ((o_wdt_ref == o_fail_mon_ref)
        and (i_ce |=> o_wdt_ref == $past(pin_level[PIN_SLOW])))
        else $error("slow rc reference not shared");
    AST_INSTR_RATE: assert property ($changed(o_instr_clk) |=> $stable(o_instr_clk))
        else $error("instruction clock faster than allowed");
    AST_GLITCH_FREE: assert property ($changed(active_src_ff) && $past(cfg_done_ff)
        |-> $fell(osc_ff))
        else $error("source changed outside a falling boundary");

    COV_SWITCH: cover property (sw_state_ff == SW_WAIT ##[1:1000] sw_state_ff == SW_DONE);
    COV_PLL_MODE: cover property ($rose(o_pll_enable));
    COV_DOZE: cover property (doze_on && $changed(o_cpu_clk));
    COV_DIVN: cover property (active_src_ff == SRC_FAST_RC_DIVN && $rose(o_osc_clk));

endmodule : clock_select_pll

// file: sim/clock_select_pll_bench.sv
`timescale 1ns/1ps
module clock_select_pll_bench;
import clk_sel_pkg::*;
logic i_mclk = 1'b0;
logic i_rst_n = 1'b0;
logic [3:0] i_address = 4'h0;
logic i_read = 1'b0;
logic i_write = 1'b0;
logic [31:0] i_writedata = 32'h0000_0000;
logic i_frc_clk = 1'b0;
logic i_slow_rc_clk = 1'b0;
logic [2:0] src_cfg = 3'h0;
logic [1:0] pm_cfg = 2'h0;
logic erased_cfg = 1'b1;
logic [31:0] o_readdata, rd;
logic o_waitrequest, o_osc_clk, o_instr_clk, o_periph_clk, o_cpu_clk, o_pll_enable;
logic o_wdt_ref, o_fail_mon_ref, o_pll_ref, o_pll_fb;
pll_cfg_t o_pll_cfg;
clk_mode_t o_clock_mode;
prim_mode_t o_primary_mode;
int errors = 0;
int n_checks = 0;
int oe, ie, ce, re, fe, split, frc_cnt;
logic [4:0] last_q;
logic [4:0] tb_pre [4] = '{5'h00, 5'h1F, 5'h05, 5'h01};
logic [1:0] tb_post [4] = '{2'h0, 2'h3, 2'h1, 2'h2};
logic [8:0] tb_fb [4] = '{9'h01E, 9'h1FF, 9'h000, 9'h0FF};
logic [3:0] tb_n2 [4] = '{4'h2, 4'h8, 4'h4, 4'h4};
clock_select_pll DUT (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_address(i_address),
    .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(4'hF),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_frc_clk(i_frc_clk),
    .i_primary_clk(1'b0), .i_lp_xtal_clk(1'b0), .i_slow_rc_clk(i_slow_rc_clk),
    .i_vco_clk(i_frc_clk), .i_initial_source_select(src_cfg), .i_primary_mode_select(pm_cfg),
    .i_config_erased(erased_cfg), .o_osc_clk(o_osc_clk), .o_instr_clk(o_instr_clk),
    .o_periph_clk(o_periph_clk), .o_cpu_clk(o_cpu_clk),
    .o_pll_ref(o_pll_ref), .o_pll_fb(o_pll_fb),
    .o_pll_enable(o_pll_enable), .o_pll_cfg(o_pll_cfg), .o_clock_mode(o_clock_mode),
    .o_primary_mode(o_primary_mode), .o_wdt_ref(o_wdt_ref), .o_fail_mon_ref(o_fail_mon_ref));
initial
begin
    forever #20 i_mclk = ~i_mclk;
end
// fast rc pin toggles every 4 cycles, so each event is 4 cycles apart
always @(posedge i_mclk)
begin
    frc_cnt <= frc_cnt + 1;
    if (frc_cnt % 4 == 3) i_frc_clk <= !i_frc_clk;
    last_q <= {o_osc_clk, o_instr_clk, o_cpu_clk, o_pll_ref, o_pll_fb};
    if (o_osc_clk === 1'b1 && last_q[4] === 1'b0) oe++;
    if (o_instr_clk === 1'b1 && last_q[3] === 1'b0) ie++;
    if (o_cpu_clk === 1'b1 && last_q[2] === 1'b0) ce++;
    if (o_pll_ref === 1'b1 && last_q[1] === 1'b0) re++;
    if (o_pll_fb === 1'b1 && last_q[0] === 1'b0) fe++;
    if (o_instr_clk !== o_periph_clk) split++;
end
task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
        $display("Result: passed");
    else
        $display("Result: failed");
    $finish;
endtask : complete_run
task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
        errors++;
        $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
endtask : check
task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    i_address <= a;
    i_writedata <= d;
    i_write <= 1'b1;
    @(posedge i_mclk);
    while (o_waitrequest !== 1'b0) @(posedge i_mclk);
    i_write <= 1'b0;
    @(posedge i_mclk);
endtask : bus_wr
task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    i_address <= a;
    i_read <= 1'b1;
    @(posedge i_mclk);
    while (o_waitrequest !== 1'b0) @(posedge i_mclk);
    d = o_readdata;
    i_read <= 1'b0;
    @(posedge i_mclk);
endtask : bus_rd
task automatic do_reset(input logic [2:0] s, input logic [1:0] p, input logic e);
    i_rst_n <= 1'b0;
    src_cfg <= s;
    pm_cfg <= p;
    erased_cfg <= e;
    repeat (6) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_mclk);
endtask : do_reset
// counts rising edges over a window of n cycles
task automatic window(input int n);
    oe = 0;
    ie = 0;
    ce = 0;
    re = 0;
    fe = 0;
    repeat (n) @(posedge i_mclk);
endtask : window
initial
begin
    logic [5:0] n1;
    logic [9:0] m;
    logic [3:0] em;
    frc_cnt = 0;
    split = 0;
    do_reset(3'h0, 2'h0, 1'b1);
    bus_rd(4'h0, rd);
    check("divisor reset", rd, 32'h0000_3040);
    bus_rd(4'h4, rd);
    check("feedback reset", rd, 32'h0000_001E);
    bus_rd(4'hC, rd);
    check("status reset", rd, 32'h0000_8204);
    check("erased mode", 32'(o_clock_mode), 32'h0000_0000);
    window(320);
    check("osc edges", 32'(oe >= 38 && oe <= 42), 32'h0000_0001);
    check("instr half", 32'(ie * 2 >= oe - 2 && ie * 2 <= oe + 2), 32'h0000_0001);
    check("cpu eq instr", 32'(ce), 32'(ie));
    // reference halves every 2 fast rc edges: period 16 cycles
    check("ref edges", 32'(re >= 18 && re <= 22), 32'h0000_0001);
    bus_wr(4'h0, 32'h0000_3840);
    repeat (40) @(posedge i_mclk);
    window(640);
    check("doze ratio", 32'(ce * 8 >= ie - 8 && ce * 8 <= ie + 8), 32'h0000_0001);
    check("periph split", 32'(split), 32'h0000_0000);
    // feedback toggles every 32 vco edges: period 256 cycles
    check("fb edges", 32'(fe >= 2 && fe <= 3), 32'h0000_0001);
    for (int i = 0; i < 4; i++)
    begin
        bus_wr(4'h0, {24'h0, tb_post[i], 1'b0, tb_pre[i]});
        bus_wr(4'h4, {23'h0, tb_fb[i]});
        repeat (40) @(posedge i_mclk);
        n1 = {1'b0, tb_pre[i]} + 6'h02;
        m = {1'b0, tb_fb[i]} + 10'h002;
        bus_rd(4'hC, rd);
        check("status", rd, {12'h0, n1, m, tb_n2[i]});
        check("pll_cfg", {12'h0, o_pll_cfg}, {12'h0, n1, m, tb_n2[i]});
        bus_rd(4'h4, rd);
        check("feedback", rd, {23'h0, tb_fb[i]});
    end
    bus_wr(4'h0, 32'h0000_FFFF);
    bus_rd(4'h0, rd);
    check("divisor mask", rd, 32'h0000_7FDF);
    // div by 4: osc toggles every 4 events, period 32 cycles
    bus_wr(4'h0, 32'h0000_0100);
    bus_wr(4'h8, 32'h0000_000F);
    repeat (80) @(posedge i_mclk);
    bus_rd(4'h8, rd);
    check("source ctrl", rd, 32'h0000_2C77);
    check("divn mode", 32'(o_clock_mode), 32'h0000_000B);
    window(640);
    check("divn edges", 32'(oe >= 18 && oe <= 22), 32'h0000_0001);
    i_slow_rc_clk <= 1'b1;
    repeat (6) @(posedge i_mclk);
    check("refs high", {30'h0, o_wdt_ref, o_fail_mon_ref}, 32'h0000_0003);
    i_slow_rc_clk <= 1'b0;
    repeat (6) @(posedge i_mclk);
    check("refs low", {30'h0, o_wdt_ref, o_fail_mon_ref}, 32'h0000_0000);
    for (int s = 0; s < 8; s++)
        for (int p = 0; p < 3; p++)
            if (p == 0 || s == 2 || s == 3)
            begin
                do_reset(3'(s), 2'(p), 1'b0);
                em = (s == 2) ? 4'(2 + p) : (s == 3) ? 4'(5 + p) : (s < 2) ? 4'(s) : 4'(s + 4);
                check("mode", 32'(o_clock_mode), 32'(em));
                check("pll on", 32'(o_pll_enable), 32'(s == 1 || s == 3));
                check("prim mode", 32'(o_primary_mode), 32'(p));
            end
    do_reset(3'h5, 2'h1, 1'b1);
    check("erased src", 32'(o_clock_mode), 32'h0000_0000);
    complete_run();
end
initial
begin
    repeat (30000) @(posedge i_mclk);
    errors++;
    complete_run();
end
endmodule : clock_select_pll_bench
